// File: design/breaker_failure_pkg.sv
// Constants, register map and state types of the breaker failure logic
package breaker_failure_pkg;
    // Clock and tick timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS       = 1000000;
    localparam int TICK_W        = 20;
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_BU_DLY  = 8'h04;
    localparam logic [7:0] ADDR_RT_DLY  = 8'h08;
    localparam logic [7:0] ADDR_PUL_DLY = 8'h0c;
    localparam logic [7:0] ADDR_PH_THR  = 8'h10;
    localparam logic [7:0] ADDR_RES_THR = 8'h14;
    localparam logic [7:0] ADDR_STATE   = 8'h18;
    localparam logic [7:0] ADDR_IRQ_ST  = 8'h1c;
    localparam logic [7:0] ADDR_IRQ_MSK = 8'h20;
    // Control field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_RT_EN    = 2;
    localparam int CTRL_SP       = 3;
    // Setting limits and reset values, in ms or current units
    localparam logic [15:0] BU_DLY_MIN  = 16'h0064;
    localparam logic [15:0] BU_DLY_MAX  = 16'hea60;
    localparam logic [15:0] BU_DLY_RST  = 16'h03e8;
    localparam logic [15:0] RT_DLY_MIN  = 16'h0000;
    localparam logic [15:0] RT_DLY_MAX  = 16'h03e8;
    localparam logic [15:0] RT_DLY_RST  = 16'h0064;
    localparam logic [15:0] PUL_DLY_MIN = 16'h0000;
    localparam logic [15:0] PUL_DLY_MAX = 16'hea60;
    localparam logic [15:0] PUL_DLY_RST = 16'h0064;
    localparam logic [15:0] PH_THR_RST  = 16'h001e;
    localparam logic [15:0] RES_THR_RST = 16'h0014;

    typedef enum logic [1:0] {
        MODE_OFF     = 2'h0,
        MODE_CURRENT = 2'h1,
        MODE_CONTACT = 2'h3,
        MODE_BOTH    = 2'h2
    } op_mode_e;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_s;

    typedef struct packed {
        logic [2:0][15:0] phase;
        logic [15:0]      res;
    } meas_s;

    typedef struct packed {
        op_mode_e         mode;
        logic             rt_en;
        logic             sp;
        logic [15:0]      bu_dly;
        logic [15:0]      rt_dly;
        logic [15:0]      pul_dly;
        logic [15:0]      ph_thr;
        logic [15:0]      res_thr;
        logic [1:0]       irq_st;
        logic [1:0]       irq_msk;
        logic [TICK_W-1:0] tick_cnt;
        logic             tick;
        logic [2:0]       start_q;
        logic [2:0]       bu_run;
        logic [2:0]       rt_run;
        logic [2:0][15:0] bu_cnt;
        logic [2:0][15:0] rt_cnt;
        logic             bu_on;
        logic [15:0]      bu_pul;
        logic [2:0]       rt_on;
        logic [2:0][15:0] rt_pul;
        logic [31:0]      rdata;
        logic             irq;
    } state_s;

    localparam state_s STATE_RST = '{
        mode:    MODE_OFF,
        bu_dly:  BU_DLY_RST,
        rt_dly:  RT_DLY_RST,
        pul_dly: PUL_DLY_RST,
        ph_thr:  PH_THR_RST,
        res_thr: RES_THR_RST,
        default: '0
    };
endpackage

// File: design/breaker_failure_logic.sv
// Breaker failure decision logic with register port and interrupt
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Start rising edge launches separate backup and retrip timers per phase.
// - Common start only in three-pole mode, phase starts in single-pole mode.
// - Current mode judges fault by overcurrent flags, ignores breaker inputs.
// - Contact mode uses breaker-closed inputs, common or per phase.
// - Combined mode resets only when current and breaker are both healthy.
// - Operation off keeps everything idle, no trip outputs.
// - Backup expiry with persisting fault asserts backup trip.
// - Trip outputs stay high at least the pulse duration.
// - Single-pole with retrip on: retrip per phase at retrip delay expiry.
// - Inhibit input suppresses operation while active.
// - Backup delay 100 to 60000 ms, default 1000.
// - Retrip delay 0 to 1000 ms, default 100.
// - Pulse duration 0 to 60000 ms, default 100.
// - Phase and residual overcurrent flags compare against thresholds.
module breaker_failure_logic
#(
    parameter int TICK_CYCLES = breaker_failure_pkg::TICK_NS / breaker_failure_pkg::CLK_PERIOD_NS
)
(
    // Clock and reset
    input  wire logic                         i_sys_clk,
    input  wire logic                         i_rst,
    // Register port
    input  wire breaker_failure_pkg::reg_req_s i_reg,
    output logic [31:0]                       o_rdata,
    output logic                              o_irq,
    // Starts, breaker status, inhibit
    input  wire logic                         i_common_start_in,
    input  wire logic [2:0]                   i_phase_start_in,
    input  wire logic                         i_breaker_closed_in,
    input  wire logic [2:0]                   i_breaker_closed_p_in,
    input  wire logic                         i_inhibit_in,
    // Current magnitudes
    input  wire breaker_failure_pkg::meas_s   i_meas,
    // Trip outputs
    output logic                              o_backup_trip_out,
    output logic [2:0]                        o_retrip_out
);
    import breaker_failure_pkg::*;

    // Ticks closer than three cycles apart would defeat the tick spacing check
    if (TICK_CYCLES < 3 || TICK_CYCLES > (2 ** TICK_W)) begin : g_bad_tick
        $error("TICK_CYCLES out of range");
    end

    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

    state_s s_reg;
    state_s s_next;

    logic       active;
    logic [2:0] oc;
    logic       oc_res;
    logic [2:0] st;
    logic [2:0] edg;
    logic [2:0] cb;
    logic [2:0] flt;
    logic [2:0] bu_fire;
    logic [2:0] rt_fire;

    function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                            input logic [15:0] hi);
        clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // Fault persists according to the supervision mode
    function automatic logic fault(input op_mode_e m, input logic cur, input logic cls);
        case (m)
            MODE_CURRENT: fault = cur;
            MODE_CONTACT: fault = cls;
            MODE_BOTH:    fault = cur | cls;
            default:      fault = 1'b0;
        endcase
    endfunction

    assign active = (s_reg.mode != MODE_OFF) && !i_inhibit_in;
    assign oc_res = i_meas.res > s_reg.res_thr;
    assign st     = s_reg.sp ? i_phase_start_in : {3{i_common_start_in}};
    assign cb     = s_reg.sp ? i_breaker_closed_p_in : {3{i_breaker_closed_in}};
    assign edg    = st & ~s_reg.start_q;

    for (genvar p = 0; p < 3; p++) begin : g_phase
        assign oc[p]  = i_meas.phase[p] > s_reg.ph_thr;
        assign flt[p] = fault(s_reg.mode, oc[p] | oc_res, cb[p]);
    end

    always_comb begin
        s_next       = s_reg;
        s_next.rdata = 32'h0;
        bu_fire      = 3'h0;
        rt_fire      = 3'h0;

        // 1 ms tick
        if (s_reg.tick_cnt == TICK_LAST) begin
            s_next.tick_cnt = '0;
            s_next.tick     = 1'b1;
        end else begin
            s_next.tick_cnt = s_reg.tick_cnt + TICK_W'(1);
            s_next.tick     = 1'b0;
        end

        s_next.start_q = st;
        for (int p = 0; p < 3; p++) begin
            if (!active) begin
                s_next.bu_run[p] = 1'b0;
                s_next.rt_run[p] = 1'b0;
            end else if (edg[p]) begin
                s_next.bu_run[p] = 1'b1;
                s_next.bu_cnt[p] = s_reg.bu_dly;
                s_next.rt_run[p] = s_reg.sp && s_reg.rt_en;
                s_next.rt_cnt[p] = s_reg.rt_dly;
            end else if (!flt[p]) begin
                s_next.bu_run[p] = 1'b0;
                s_next.rt_run[p] = 1'b0;
            end else begin
                if (s_reg.bu_run[p]) begin
                    if (s_reg.bu_cnt[p] == 16'h0) begin
                        s_next.bu_run[p] = 1'b0;
                        bu_fire[p]       = 1'b1;
                    end else if (s_reg.tick) begin
                        s_next.bu_cnt[p] = s_reg.bu_cnt[p] - 16'h1;
                    end
                end
                if (s_reg.rt_run[p]) begin
                    if (s_reg.rt_cnt[p] == 16'h0) begin
                        s_next.rt_run[p] = 1'b0;
                        rt_fire[p]       = s_reg.sp && s_reg.rt_en;
                    end else if (s_reg.tick) begin
                        s_next.rt_cnt[p] = s_reg.rt_cnt[p] - 16'h1;
                    end
                end
            end

            // Retrip pulse per phase
            if (!active) begin
                s_next.rt_on[p] = 1'b0;
            end else if (rt_fire[p]) begin
                s_next.rt_on[p]  = 1'b1;
                s_next.rt_pul[p] = s_reg.pul_dly;
            end else if (s_reg.rt_on[p]) begin
                if (s_reg.rt_pul[p] == 16'h0) begin
                    s_next.rt_on[p] = 1'b0;
                end else if (s_reg.tick) begin
                    s_next.rt_pul[p] = s_reg.rt_pul[p] - 16'h1;
                end
            end
        end

        // Backup trip pulse
        if (!active) begin
            s_next.bu_on = 1'b0;
        end else if (|bu_fire) begin
            s_next.bu_on  = 1'b1;
            s_next.bu_pul = s_reg.pul_dly;
        end else if (s_reg.bu_on) begin
            if (s_reg.bu_pul == 16'h0) begin
                s_next.bu_on = 1'b0;
            end else if (s_reg.tick) begin
                s_next.bu_pul = s_reg.bu_pul - 16'h1;
            end
        end

        // Register writes; settings clamped to their legal ranges
        if (i_reg.wr) begin
            case (i_reg.addr)
                ADDR_CTRL: begin
                    s_next.mode  = op_mode_e'(i_reg.wdata[CTRL_MODE_LSB +: 2]);
                    s_next.rt_en = i_reg.wdata[CTRL_RT_EN];
                    s_next.sp    = i_reg.wdata[CTRL_SP];
                end
                ADDR_BU_DLY:  s_next.bu_dly  = clamp16(i_reg.wdata[15:0], BU_DLY_MIN, BU_DLY_MAX);
                ADDR_RT_DLY:  s_next.rt_dly  = clamp16(i_reg.wdata[15:0], RT_DLY_MIN, RT_DLY_MAX);
                ADDR_PUL_DLY: s_next.pul_dly = clamp16(i_reg.wdata[15:0], PUL_DLY_MIN, PUL_DLY_MAX);
                ADDR_PH_THR:  s_next.ph_thr  = i_reg.wdata[15:0];
                ADDR_RES_THR: s_next.res_thr = i_reg.wdata[15:0];
                ADDR_IRQ_ST:  s_next.irq_st  = s_reg.irq_st & ~i_reg.wdata[1:0];
                ADDR_IRQ_MSK: s_next.irq_msk = i_reg.wdata[1:0];
                default: begin
                end
            endcase
        end
        // Events win over a same-cycle clear
        s_next.irq_st = s_next.irq_st | {|rt_fire, |bu_fire};
        s_next.irq    = |(s_next.irq_st & s_next.irq_msk);

        if (i_reg.rd) begin
            case (i_reg.addr)
                ADDR_CTRL:    s_next.rdata = {28'h0, s_reg.sp, s_reg.rt_en, s_reg.mode};
                ADDR_BU_DLY:  s_next.rdata = {16'h0, s_reg.bu_dly};
                ADDR_RT_DLY:  s_next.rdata = {16'h0, s_reg.rt_dly};
                ADDR_PUL_DLY: s_next.rdata = {16'h0, s_reg.pul_dly};
                ADDR_PH_THR:  s_next.rdata = {16'h0, s_reg.ph_thr};
                ADDR_RES_THR: s_next.rdata = {16'h0, s_reg.res_thr};
                ADDR_STATE:   s_next.rdata = {18'h0, oc_res, oc, s_reg.rt_run, s_reg.bu_run,
                                              s_reg.rt_on, s_reg.bu_on};
                ADDR_IRQ_ST:  s_next.rdata = {30'h0, s_reg.irq_st};
                ADDR_IRQ_MSK: s_next.rdata = {30'h0, s_reg.irq_msk};
                default:      s_next.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            s_reg <= STATE_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_rdata           = s_reg.rdata;
    assign o_irq             = s_reg.irq;
    assign o_backup_trip_out = s_reg.bu_on;
    assign o_retrip_out      = s_reg.rt_on;

    default clocking dc @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    sequence seq_bu_expire;
        s_reg.bu_run[0] && (s_reg.bu_cnt[0] == 16'h0) && flt[0] && active && !edg[0];
    endsequence

    sequence seq_trip_started;
        $rose(o_backup_trip_out) && (s_reg.bu_pul != 16'h0) && active;
    endsequence

    chk_start_arms_timer: assert property (
        edg[0] && active |=> s_reg.bu_run[0] && (s_reg.bu_cnt[0] == $past(s_reg.bu_dly)))
        else $error("start edge did not arm backup timer");

    chk_common_start_fans: assert property (
        !s_reg.sp && active && i_common_start_in && !s_reg.start_q[1] |=> s_reg.bu_run[1])
        else $error("common start did not reach phase 2");

    chk_current_mode_reset: assert property (
        (s_reg.mode == MODE_CURRENT) && active && !edg[0] && !(oc[0] || oc_res)
        |=> !s_reg.bu_run[0])
        else $error("current mode kept timer without overcurrent");

    chk_contact_mode_reset: assert property (
        (s_reg.mode == MODE_CONTACT) && active && !edg[0] && !cb[0] |=> !s_reg.bu_run[0])
        else $error("contact mode kept timer with breaker open");

    chk_both_mode_hold: assert property (
        (s_reg.mode == MODE_BOTH) && active && !edg[0] && s_reg.bu_run[0]
        && (s_reg.bu_cnt[0] != 16'h0) && (cb[0] || oc[0] || oc_res) |=> s_reg.bu_run[0])
        else $error("combined mode reset while a fault remained");

    chk_off_quiet: assert property (
        s_reg.mode == MODE_OFF |=> !o_backup_trip_out && (o_retrip_out == 3'h0))
        else $error("trip output while operation off");

    chk_expire_trips: assert property (
        seq_bu_expire |=> o_backup_trip_out)
        else $error("backup expiry did not trip");

    chk_pulse_holds: assert property (
        seq_trip_started |=> o_backup_trip_out)
        else $error("backup trip dropped before pulse duration");

    chk_retrip_enabled: assert property (
        (|(o_retrip_out & ~$past(o_retrip_out))) |-> $past(s_reg.sp && s_reg.rt_en))
        else $error("retrip without single-pole retrip enable");

    chk_sp_ignores_common: assert property (
        s_reg.sp && !(i_phase_start_in[1] && !s_reg.start_q[1]) && !s_reg.bu_run[1] |=> !s_reg.bu_run[1])
        else $error("phase 2 armed without its own start");

    chk_bu_pulse_run: assert property (
        o_backup_trip_out && (s_reg.bu_pul != 16'h0) && active |=> o_backup_trip_out)
        else $error("backup trip dropped with pulse time left");

    chk_rt_pulse_run: assert property (
        o_retrip_out[1] && (s_reg.rt_pul[1] != 16'h0) && active |=> o_retrip_out[1])
        else $error("retrip dropped with pulse time left");

    chk_bu_dly_range: assert property (
        (s_reg.bu_dly >= BU_DLY_MIN) && (s_reg.bu_dly <= BU_DLY_MAX))
        else $error("backup delay outside its range");

    chk_rt_dly_range: assert property (
        s_reg.rt_dly <= RT_DLY_MAX)
        else $error("retrip delay outside its range");

    chk_pul_dly_range: assert property (
        s_reg.pul_dly <= PUL_DLY_MAX)
        else $error("pulse duration outside its range");

    chk_inhibit_quiet: assert property (
        i_inhibit_in |=> !o_backup_trip_out && (o_retrip_out == 3'h0))
        else $error("trip output while inhibited");

    chk_tick_single: assert property (
        s_reg.tick |=> !s_reg.tick ##1 !s_reg.tick)
        else $error("tick pulses too close");

endmodule // breaker_failure_logic

`default_nettype wire

// File: verif/fault_source_model.sv
// Far-side model: protection starts' currents and breaker contacts feeding the logic
`timescale 1ns/1ps
`default_nettype none

module fault_source_model
(
    // Clock
    input  wire logic                  i_sys_clk,
    // Commanded plant state
    input  wire logic [2:0]            i_oc,
    input  wire logic                  i_res_oc,
    input  wire logic [2:0]            i_closed,
    input  wire logic [15:0]           i_ph_thr,
    input  wire logic [15:0]           i_res_thr,
    // Toward the logic
    output var  breaker_failure_pkg::meas_s o_meas,
    output logic                       o_breaker_closed_in,
    output logic [2:0]                 o_breaker_closed_p_in
);
    import breaker_failure_pkg::*;

    integer seed = 45;

    // A quiet channel may sit exactly on its threshold, which must not count as overcurrent
    function automatic logic [15:0] lvl(input logic hi, input logic [15:0] thr);
        logic [15:0] r;
        r = 16'($random(seed)) & 16'h003f;
        return hi ? thr + 16'h0001 + r : thr - (r & 16'h0003);
    endfunction

    always @(posedge i_sys_clk) begin
        for (int p = 0; p < 3; p++) begin
            o_meas.phase[p] <= lvl(i_oc[p], i_ph_thr);
        end
        o_meas.res <= lvl(i_res_oc, i_res_thr);
    end

    assign o_breaker_closed_in   = |i_closed;
    assign o_breaker_closed_p_in = i_closed;
endmodule // fault_source_model

`default_nettype wire

// File: verif/breaker_failure_logic_tb.sv
// Self-checking bench for the breaker failure logic
`timescale 1ns/1ps
`default_nettype none

module breaker_failure_logic_tb;
    import breaker_failure_pkg::*;
    localparam int TK = 4;
    logic        i_sys_clk = 1'b0;
    logic        i_rst = 1'b1;
    reg_req_s    reg_q = '0;
    logic [31:0] o_rdata;
    logic        o_irq;
    logic        bu_trip;
    logic [2:0]  rt_trip;
    logic        common_start = 1'b0;
    logic [2:0]  phase_start = '0;
    logic        inhibit = 1'b0;
    logic [2:0]  oc = '0;
    logic        res_oc = 1'b0;
    logic [2:0]  closed = '0;
    logic        bcl;
    logic [2:0]  bcl_p;
    meas_s       meas;
    logic [31:0] d;
    logic [7:0]  ra[8] = '{ADDR_CTRL, ADDR_BU_DLY, ADDR_RT_DLY, ADDR_PUL_DLY,
                           ADDR_PH_THR, ADDR_RES_THR, ADDR_IRQ_MSK, 8'h30};
    logic [15:0] rv[8] = '{16'h0, BU_DLY_RST, RT_DLY_RST, PUL_DLY_RST,
                           PH_THR_RST, RES_THR_RST, 16'h0, 16'h0};
    int          error_cnt = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    int          ncase = 0;

    always #5 i_sys_clk = ~i_sys_clk;

    breaker_failure_logic #(.TICK_CYCLES(TK)) u_breaker_failure_logic (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_reg(reg_q), .o_rdata(o_rdata),
        .o_irq(o_irq), .i_common_start_in(common_start), .i_phase_start_in(phase_start),
        .i_breaker_closed_in(bcl), .i_breaker_closed_p_in(bcl_p), .i_inhibit_in(inhibit),
        .i_meas(meas), .o_backup_trip_out(bu_trip), .o_retrip_out(rt_trip)
    );

    fault_source_model u_fault_source_model (
        .i_sys_clk(i_sys_clk), .i_oc(oc), .i_res_oc(res_oc), .i_closed(closed),
        .i_ph_thr(PH_THR_RST), .i_res_thr(RES_THR_RST), .o_meas(meas),
        .o_breaker_closed_in(bcl), .o_breaker_closed_p_in(bcl_p)
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_sys_clk);
        reg_q <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge i_sys_clk);
        reg_q.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge i_sys_clk);
        reg_q <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge i_sys_clk);
        reg_q.rd <= 1'b0;
        #1 d = o_rdata;
    endtask

    task automatic wrrd(input logic [7:0] a, input logic [31:0] v, input logic [15:0] e);
        wr(a, v);
        rd(a);
        check(d, {16'h0, e});
    endtask

    // Expected outcome per phase is worked out first, then the response is timed
    task automatic run(input op_mode_e md, input bit sp, rt, inh, ph, input logic [2:0] o,
                       input bit r, input logic [2:0] cb, input bit rs);
        logic [2:0] stp;
        logic [2:0] f;
        bit         fc;
        bit         fk;
        bit         act;
        int         t0;
        int         bu_t;
        int         bu_len;
        int         rt_t[3];
        stp = sp ? (ph ? 3'b010 : 3'b000) : (ph ? 3'b000 : 3'b111);
        for (int p = 0; p < 3; p++) begin
            fc = o[p] | r;
            fk = sp ? cb[p] : |cb;
            f[p] = stp[p] && !inh && (md == MODE_CURRENT ? fc : md == MODE_CONTACT ? fk :
                                      md == MODE_BOTH ? (fc | fk) : 1'b0);
        end
        wr(ADDR_CTRL, {28'h0, sp, rt, md});
        @(posedge i_sys_clk);
        oc <= o;
        res_oc <= r;
        closed <= cb;
        inhibit <= inh;
        t0 = rs ? 150 : 0;
        bu_t = -1;
        bu_len = 0;
        rt_t = '{-1, -1, -1};
        for (int c = 0; c < 600; c++) begin
            @(posedge i_sys_clk);
            act = c < 2 || (rs && c >= 150 && c < 152);
            common_start <= !ph && act;
            phase_start <= {1'b0, ph && act, 1'b0};
            #1;
            if (bu_trip === 1'b1 && bu_t < 0) bu_t = c;
            if (bu_trip === 1'b1 && bu_t + bu_len == c) bu_len++;
            for (int p = 0; p < 3; p++) begin
                if (rt_trip[p] === 1'b1 && rt_t[p] < 0) rt_t[p] = c;
            end
        end
        check(32'(bu_t >= 0), 32'(|f));
        if (|f) begin
            check(32'(bu_t - t0 >= 99 * TK && bu_t - t0 <= 100 * TK + 6), 1);
            check(32'(bu_len > 4 * TK && bu_len <= 6 * TK + 2), 1);
        end
        for (int p = 0; p < 3; p++) begin
            check(32'(rt_t[p] >= 0), 32'(f[p] & sp & rt));
            if (f[p] & sp & rt) check(32'(rt_t[p] >= 9 * TK && rt_t[p] <= 10 * TK + 6), 1);
        end
        ncase++;
        $display("case %0d finished", ncase);
    endtask

    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 12000) begin
            error_cnt++;
            wrap_up();
        end
    end

    initial begin
        repeat (16) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(ra[i]);
            check(d, {16'h0, rv[i]});
        end
        wrrd(ADDR_BU_DLY, 32'hffff, BU_DLY_MAX);
        wrrd(ADDR_BU_DLY, 32'h5, BU_DLY_MIN);
        wrrd(ADDR_RT_DLY, 32'h7d0, RT_DLY_MAX);
        wrrd(ADDR_RT_DLY, 32'ha, 16'h000a);
        wrrd(ADDR_PUL_DLY, 32'hffff, PUL_DLY_MAX);
        wrrd(ADDR_PUL_DLY, 32'h5, 16'h0005);
        wrrd(ADDR_PH_THR, 32'hffff_1234, 16'h1234);
        wrrd(ADDR_PH_THR, 32'(PH_THR_RST), PH_THR_RST);
        wrrd(ADDR_RES_THR, 32'h0000_0041, 16'h0041);
        wrrd(ADDR_RES_THR, 32'(RES_THR_RST), RES_THR_RST);
        run(MODE_OFF, 0, 0, 0, 0, 3'b111, 1, 3'b111, 0);
        run(MODE_CURRENT, 0, 0, 0, 0, 3'b001, 0, 3'b000, 0);
        run(MODE_CURRENT, 0, 0, 0, 0, 3'b000, 0, 3'b111, 0);
        run(MODE_CURRENT, 0, 0, 0, 0, 3'b000, 1, 3'b000, 1);
        run(MODE_CONTACT, 0, 0, 0, 0, 3'b111, 1, 3'b000, 0);
        run(MODE_CONTACT, 0, 0, 0, 0, 3'b000, 0, 3'b100, 0);
        run(MODE_BOTH, 0, 0, 0, 0, 3'b000, 0, 3'b010, 0);
        run(MODE_BOTH, 0, 0, 0, 0, 3'b000, 0, 3'b000, 0);
        run(MODE_CURRENT, 0, 0, 1, 0, 3'b111, 1, 3'b111, 0);
        run(MODE_CURRENT, 0, 0, 0, 1, 3'b111, 1, 3'b111, 0);
        run(MODE_CURRENT, 1, 1, 0, 1, 3'b010, 0, 3'b000, 0);
        run(MODE_CONTACT, 1, 1, 0, 1, 3'b000, 0, 3'b101, 0);
        run(MODE_CURRENT, 1, 0, 0, 1, 3'b010, 0, 3'b000, 0);
        run(MODE_CURRENT, 1, 1, 0, 0, 3'b111, 1, 3'b111, 0);
        rd(ADDR_STATE);
        check(d, 32'h0000_3c00);
        rd(ADDR_IRQ_ST);
        check(d, 32'h3);
        check(o_irq, 1'b0);
        wr(ADDR_IRQ_MSK, 32'h1);
        @(posedge i_sys_clk);
        #1 check(o_irq, 1'b1);
        wr(ADDR_IRQ_ST, 32'h1);
        @(posedge i_sys_clk);
        #1 check(o_irq, 1'b0);
        rd(ADDR_IRQ_ST);
        check(d, 32'h2);
        $display("case irq finished");
        wrap_up();
    end
endmodule // breaker_failure_logic_tb

`default_nettype wire
